// [tcp_phy_enable.sv]
// Purpose: select which SuperSpeed PHY of each attach channel is powered
// Assumes: pins synchronous-ish; two-flop synchronised before use
// Notes:   AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"

// Summary of operation
// - polarity strap low: attach input 1 powers its PHY, 0 powers it off.
// - polarity strap high: attach input 0 powers the PHY, 1 powers it off.
// - no attach indicated keeps the channel PHYs off to save power.
// - polarity low: orientation 1 selects PHY B, 0 selects PHY A.
// - polarity high: orientation 1 selects PHY A, 0 selects PHY B.
// - orientation alone enables nothing; the attach input must also assert.
// - per-orientation attach inputs are used only with mode strap high.
// - mode 2: orientation-A attach powers the port channel's PHY A, deasserted powers it off.
// - orientation-A attach is active high, or active low with polarity high.
// - mode strap low or open selects mode 1 attach and orientation inputs.
module tcp_phy_enable (
	input  wire logic                CLK_I,
	input  wire logic                RST_I,
	input  wire tcp_pkg::tcp_pins_t  PINS_I,
	input  wire tcp_pkg::tcp_ahb_req_t AHB_I,
	input  wire logic [31:0]         HWDATA_I,
	output logic [31:0]              HRDATA_O,
	output logic                     HREADYOUT_O,
	output logic                     HRESP_O,
	output logic [tcp_pkg::TCP_NCH-1:0] PHY_A_EN_O,
	output logic [tcp_pkg::TCP_NCH-1:0] PHY_B_EN_O
);
	import tcp_pkg::*;

	localparam int PW = $bits(tcp_pins_t);

	// input synchroniser
	logic [PW-1:0]  sync1_ff;
	logic [PW-1:0]  sync2_ff;
	logic [PW-1:0]  nxt_sync1;
	logic [PW-1:0]  nxt_sync2;
	tcp_pins_t      pins_s;

	always_comb begin
		nxt_sync1 = PINS_I;
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	assign pins_s = tcp_pins_t'(sync2_ff);

	// enable decode
	logic [TCP_NCH-1:0] mask_ff;
	logic [TCP_NCH-1:0] en_a_ff;
	logic [TCP_NCH-1:0] en_b_ff;
	logic [TCP_NCH-1:0] nxt_en_a;
	logic [TCP_NCH-1:0] nxt_en_b;
	logic [TCP_NCH-1:0] att_act;
	logic               ori_b;
	logic               mux_a_act;
	logic               mux_b_act;
	logic               mode2;

	assign att_act   = pins_s.attach_in ^ {TCP_NCH{pins_s.attach_polarity_strap}};
	assign ori_b     = pins_s.orient_sel_in ^ pins_s.attach_polarity_strap;
	assign mux_a_act = pins_s.orient_a_attach_in ^ pins_s.attach_polarity_strap;
	assign mux_b_act = pins_s.orient_b_attach_in ^ pins_s.attach_polarity_strap;
	assign mode2     = pins_s.ctrl_mode_select_strap;

	genvar gi;
	generate
		for (gi = 0; gi < TCP_NCH; gi++) begin : g_ch
			logic m2_a;
			logic m2_b;
			// mode 2 drives only the Type-C port channel
			if (gi == `TCP_PORT0) begin : g_port
				assign m2_a = mux_a_act;
				assign m2_b = mux_b_act;
			end else begin : g_other
				assign m2_a = 1'b0;
				assign m2_b = 1'b0;
			end
			always_comb begin
				if (mode2) begin
					nxt_en_a[gi] = mask_ff[gi] & m2_a;
					nxt_en_b[gi] = mask_ff[gi] & m2_b;
				end else begin
					nxt_en_a[gi] = mask_ff[gi] & att_act[gi] & ~ori_b;
					nxt_en_b[gi] = mask_ff[gi] & att_act[gi] & ori_b;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			en_a_ff <= '0;
			en_b_ff <= '0;
		end else begin
			en_a_ff <= nxt_en_a;
			en_b_ff <= nxt_en_b;
		end
	end

	assign PHY_A_EN_O = en_a_ff;
	assign PHY_B_EN_O = en_b_ff;

	// AHB-Lite slave
	logic                 wr_pend_ff;
	logic [`TCP_AW-1:0]   wr_addr_ff;
	logic [31:0]          rdata_ff;
	logic                 nxt_wr_pend;
	logic [`TCP_AW-1:0]   nxt_wr_addr;
	logic [31:0]          nxt_rdata;
	logic [TCP_NCH-1:0]   nxt_mask;
	logic                 take;
	logic [`TCP_AW-1:0]   a_lo;

	assign take = AHB_I.hsel & AHB_I.hready & AHB_I.htrans[`TCP_HTRANS_BIT];
	assign a_lo = AHB_I.haddr[`TCP_AW-1:0];

	always_comb begin
		nxt_wr_pend = take & AHB_I.hwrite;
		nxt_wr_addr = wr_pend_ff ? wr_addr_ff : a_lo;
		if (take) begin
			nxt_wr_addr = a_lo;
		end
		nxt_rdata = rdata_ff;
		if (take & ~AHB_I.hwrite) begin
			case (a_lo)
				`TCP_CTRL_OFS: begin
					nxt_rdata = {`TCP_CTRL_PAD, mask_ff};
				end
				`TCP_STAT_OFS: begin
					nxt_rdata = {`TCP_STAT_PAD, sync2_ff};
				end
				`TCP_EN_OFS: begin
					nxt_rdata = {`TCP_EN_PAD, en_b_ff, en_a_ff};
				end
				default: begin
					nxt_rdata = `TCP_ZERO32;
				end
			endcase
		end
		nxt_mask = mask_ff;
		if (wr_pend_ff && wr_addr_ff == `TCP_CTRL_OFS) begin
			nxt_mask = HWDATA_I[`TCP_MASK_MSB:`TCP_MASK_LSB];
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			rdata_ff   <= `TCP_ZERO32;
			mask_ff    <= `TCP_MASK_RST;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff   <= nxt_rdata;
			mask_ff    <= nxt_mask;
		end
	end

	assign HRDATA_O    = rdata_ff;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = 1'b0;

endmodule : tcp_phy_enable
`default_nettype wire

// [tcp_map.svh]
// Purpose: constants for the Type-C attach PHY enable block
// Assumes: AHB-Lite register window decoded on the low address byte
// Notes:   offsets are byte addresses of 32-bit registers
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

`define TCP_AW          8
`define TCP_CTRL_OFS    8'h00
`define TCP_STAT_OFS    8'h04
`define TCP_EN_OFS      8'h08
`define TCP_MASK_RST    3'h7
`define TCP_MASK_LSB    0
`define TCP_MASK_MSB    2
`define TCP_PORT0       0
`define TCP_STAT_PAD    24'h000000
`define TCP_EN_PAD      26'h0000000
`define TCP_CTRL_PAD    29'h00000000
`define TCP_ZERO32      32'h00000000
`define TCP_HTRANS_BIT  1

`endif

// [tcp_pkg.sv]
// Purpose: types for the Type-C attach PHY enable block
// Assumes: three attach channels, each with an A and a B PHY
// Notes:   struct bit order also gives the status register layout
package tcp_pkg;

	localparam int TCP_NCH = 3;

	typedef struct packed {
		logic [TCP_NCH-1:0] attach_in;
		logic               orient_sel_in;
		logic               attach_polarity_strap;
		logic               ctrl_mode_select_strap;
		logic               orient_a_attach_in;
		logic               orient_b_attach_in;
	} tcp_pins_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} tcp_ahb_req_t;

endpackage : tcp_pkg

// [tcp_phy_enable_monitor.sv]
// Purpose: enable output checks
// Assumes: pins held 5 edges are settled
// Notes: off cases only, mask only gates
`timescale 1ns/1ps
`default_nettype none
module tcp_phy_enable_monitor import tcp_pkg::*; (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire tcp_pins_t PINS_I,
	input wire logic [TCP_NCH-1:0] PHY_A_EN_O,
	input wire logic [TCP_NCH-1:0] PHY_B_EN_O
);
	tcp_pins_t p_ff;
	logic [2:0] cnt_ff;
	wire logic pol = p_ff.attach_polarity_strap;
	wire logic s = cnt_ff == 3'h5;
	wire logic m1 = s & !p_ff.ctrl_mode_select_strap;
	wire logic m2 = s & p_ff.ctrl_mode_select_strap;
	wire logic [2:0] act = p_ff.attach_in ^ {3{pol}};
	wire logic [2:0] wb = act & {3{p_ff.orient_sel_in ^ pol}};
	wire logic [2:0] wa = act & ~wb;
	always_ff @(posedge CLK_I) p_ff <= PINS_I;
	// counts edges the pins stood still
	always_ff @(posedge CLK_I or posedge RST_I)
		if (RST_I) cnt_ff <= 3'h0;
		else cnt_ff <= PINS_I != p_ff ? 3'h0 : cnt_ff + 3'(!s);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	chk_a_attach: assert property (m1 |-> !(PHY_A_EN_O & ~wa))
		else $error("stray A enable");
	chk_b_orient: assert property (m1 |-> !(PHY_B_EN_O & ~wb))
		else $error("stray B enable");
	chk_idle_off: assert property (m1 && !act |-> !(PHY_A_EN_O | PHY_B_EN_O))
		else $error("PHY on while idle");
	chk_one_phy: assert property (m1 |-> !(PHY_A_EN_O & PHY_B_EN_O))
		else $error("A and B both on");
	chk_pol_high: assert property (m1 && pol && &p_ff.attach_in |-> !PHY_A_EN_O)
		else $error("inverted idle on");
	chk_m2_a: assert property (m2 && p_ff.orient_a_attach_in == pol |-> !PHY_A_EN_O[0])
		else $error("mode 2 A on");
	chk_m2_b: assert property (m2 && p_ff.orient_b_attach_in == pol |-> !PHY_B_EN_O[0])
		else $error("mode 2 B on");
	chk_m2_mux: assert property (m2 |-> !(PHY_A_EN_O[2:1] | PHY_B_EN_O[2:1]))
		else $error("mode 1 input used");
endmodule : tcp_phy_enable_monitor
`default_nettype wire
bind tcp_phy_enable tcp_phy_enable_monitor tcp_phy_enable_monitor_i (.CLK_I(CLK_I),
	.RST_I(RST_I), .PINS_I(PINS_I), .PHY_A_EN_O(PHY_A_EN_O), .PHY_B_EN_O(PHY_B_EN_O));

// [tcp_cc_model.sv]
// Purpose: CC controller stand-in
// Assumes: inputs in logical sense
// Notes: board strap sets pin polarity
`timescale 1ns/1ps
`default_nettype none
module tcp_cc_model import tcp_pkg::*; (
	input wire logic [2:0] att_i,
	input wire logic flip_i,
	input wire logic pol_i,
	input wire logic m2_i,
	output var tcp_pins_t pins_o
);
	// strap high makes every attach and orientation pin active low
	assign pins_o = {att_i ^ {3{pol_i}}, flip_i ^ pol_i, pol_i, m2_i,
		(att_i[0] & !flip_i) ^ pol_i, (att_i[0] & flip_i) ^ pol_i};
endmodule : tcp_cc_model
`default_nettype wire

// [tcp_phy_enable_tb.sv]
// Purpose: self-checking bench
// Assumes: zero-wait bus slave
// Notes: enables judged 6 edges after pins move
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_phy_enable_tb;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, m2 = 1'b0, rdy, resp;
	logic [4:0] pv = 5'h0;
	logic [1:0] tr = 2'h0;
	logic [7:0] a8 = 8'h0;
	logic [31:0] hw = 32'h0, rd, q;
	logic [2:0] ea, eb;
	tcp_pkg::tcp_pins_t pins;
	int fails = 0, checked = 0;
	tcp_cc_model tcp_cc_model_i (.att_i(pv[2:0]), .flip_i(pv[3]),
		.pol_i(pv[4]), .m2_i(m2), .pins_o(pins));
	tcp_phy_enable tcp_phy_enable_i (.CLK_I(clk), .RST_I(rst), .PINS_I(pins),
		.AHB_I({tr[1], 24'h0, a8, tr, wr, 3'h2, rdy}), .HWDATA_I(hw),
		.HRDATA_O(rd), .HREADYOUT_O(rdy), .HRESP_O(resp),
		.PHY_A_EN_O(ea), .PHY_B_EN_O(eb));
	initial forever #12.5 clk = ~clk;
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task complete_run;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task hop;
		for (int n = 0; n < 9; n++) begin
			@(posedge clk);
			if (rdy === 1'b1) return;
		end
		fails++;
		complete_run();
	endtask : hop
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		{tr, wr, a8} <= {2'h2, w, a};
		hop();
		{tr, hw} <= {2'h0, d};
		hop();
		q = rd;
		cmp({31'h0, resp}, 32'h0);
	endtask : bus
	task cmp_en(input logic [5:0] exp);
		repeat (6) @(posedge clk);
		cmp({26'h0, eb, ea}, {26'h0, exp});
	endtask : cmp_en
	task t_regs;
		pv <= 5'h07;
		bus(1'b0, `TCP_CTRL_OFS, 32'h0);
		cmp(q, {29'h0, `TCP_MASK_RST});
		bus(1'b1, `TCP_CTRL_OFS, 32'h1);
		cmp_en(6'h01);
		bus(1'b0, `TCP_EN_OFS, 32'h0);
		cmp(q, 32'h1);
		bus(1'b0, `TCP_STAT_OFS, 32'h0);
		cmp(q, 32'hE2);
		bus(1'b0, 8'h10, 32'h0);
		cmp(q, 32'h0);
		bus(1'b1, `TCP_CTRL_OFS, 32'h7);
	endtask : t_regs
	task t_mode1;
		for (int i = 0; i < 32; i++) begin
			pv <= 5'(i);
			cmp_en(i[3] ? {i[2:0], 3'h0} : {3'h0, i[2:0]});
		end
	endtask : t_mode1
	task t_mode2;
		m2 <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			pv <= {i[2:1], 2'h3, i[0]};
			cmp_en({2'h0, i[0] & i[1], 2'h0, i[0] & ~i[1]});
		end
		m2 <= 1'b0;
	endtask : t_mode2
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_mode1();
		t_mode2();
		complete_run();
	end
endmodule : tcp_phy_enable_tb
`default_nettype wire
